// [design/ccp_compare_event_pwm.sv]
// compare special modes and pwm generator behind an apb slave
// assumes one 100 MHz clock; t1_ext_in is an unsynchronised pin
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module ccp_compare_event_pwm import ccp_pkg::*; #(
	parameter int T1_WIDTH = 16,
	parameter int T2_WIDTH = 8
) (
	input wire logic sys_clk, // system clock, 100 MHz
	input wire logic resetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic t1_ext_in, // external timer1 clock pin
	input wire logic adc_enable, // converter is enabled
	output logic adc_start, // pulse: start a conversion
	output logic special_event, // level: special event trigger
	output logic unit_output_pin_o, // output pin level
	output logic unit_output_pin_oe_n // output enable, low drives
);
	if (T1_WIDTH != 16 || T2_WIDTH != 8) begin : g_chk
		$error("ccp_compare_event_pwm: timer widths are fixed");
	end

	localparam int DUTY_W = T2_WIDTH + 2;

	logic [3:0] mode_q;
	logic [1:0] dlb_q;
	logic [7:0] duty_low_q;
	logic [7:0] duty_high_q;
	logic [1:0] latch_q;
	logic [7:0] period_q;
	logic [4:0] tcfg_q;
	logic [2:0] flags_q;
	logic [1:0] phase_q;
	logic [2:0] ext_sync_q;
	logic match_prev_q;
	logic period_end_q;
	logic out_q;
	logic adc_start_q;
	logic [31:0] prdata_q;
	logic pslverr_q;

	logic wr;
	logic setup_rd;
	logic [31:0] rd_val;
	logic mapped;
	logic pwm_mode;
	logic special_mode;
	logic match;
	logic t1_tick;
	logic t1_clear;
	logic t1_load;
	logic t1_ovf;
	logic [15:0] t1_count;
	logic t2_load;
	logic [7:0] t2_count;
	logic [1:0] t2_low;
	logic period_end;
	logic [DUTY_W-1:0] timebase;
	logic [DUTY_W-1:0] duty_buf;
	logic [DUTY_W-1:0] duty_next;
	logic ctrl_zero_wr;
	logic [2:0] flag_set;
	logic [2:0] flag_clr;

	// apb decode; every register answers with no wait state
	assign wr = psel && penable && pwrite;
	assign setup_rd = psel && !penable;
	assign pready = psel && penable;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign ctrl_zero_wr = wr && (paddr == CTRL_OFS) &&
		(pwdata[7:0] == 8'h00);

	// mode grouping
	assign pwm_mode = (mode_q[3:2] == MODE_PWM_GRP);
	assign special_mode = (mode_q == MODE_SPECIAL);

	// control: mode select and the two low duty bits
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= MODE_OFF;
			dlb_q <= 2'h0;
		end else if (wr && paddr == CTRL_OFS) begin
			mode_q <= pwdata[MODE_LSB +: 4];
			dlb_q <= pwdata[DLB_LSB +: 2];
		end
	end

	// low compare/duty byte may be written in any mode
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			duty_low_q <= 8'h00;
		end else if (wr && paddr == DUTY_LOW_OFS) begin
			duty_low_q <= pwdata[7:0];
		end
	end

	// high byte and hidden latch form the active duty buffer;
	// in pwm software cannot touch it, so the pin never glitches
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			duty_high_q <= 8'h00;
			latch_q <= 2'h0;
		end else if (pwm_mode) begin
			if (period_end) begin
				duty_high_q <= duty_low_q;
				latch_q <= dlb_q;
			end
		end else if (wr && paddr == DUTY_HIGH_OFS) begin
			duty_high_q <= pwdata[7:0];
		end
	end

	// period limit and timer configuration
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			period_q <= PERIOD_RST;
			tcfg_q <= 5'h00;
		end else if (wr) begin
			if (paddr == PERIOD_OFS) begin
				period_q <= pwdata[7:0];
			end
			if (paddr == TCFG_OFS) begin
				tcfg_q <= pwdata[4:0];
			end
		end
	end

	// instruction phase, and the external pin through two flops
	// before the edge detector looks at it
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			phase_q <= 2'h0;
			ext_sync_q <= 3'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
			ext_sync_q <= {ext_sync_q[1:0], t1_ext_in};
		end
	end

	// timer1 steps on the instruction clock or a synced pin edge;
	// a truly asynchronous counter is not offered at all
	assign t1_tick = tcfg_q[T1_ON_BIT] && (tcfg_q[T1_EXT_BIT] ?
		(ext_sync_q[1] && !ext_sync_q[2]) :
		(phase_q == PHASE_LAST));
	assign t1_load = wr && (paddr == T1_COUNT_OFS);

	// compare value against the live count, no register between
	assign match = (t1_count == {duty_high_q, duty_low_q});
	assign special_event = special_mode && match;
	// match is looked at again on the tick, so a changed compare
	// value in between cancels the clear
	assign t1_clear = t1_tick && special_mode && match;

	timer1_counter #(
		.WIDTH(T1_WIDTH)
	) u_timer1 (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.tick(t1_tick),
		.clear(t1_clear),
		.load(t1_load),
		.load_val(pwdata[15:0]),
		.count_q(t1_count),
		.overflow(t1_ovf)
	);

	// timer2 and its prescaler; no postscaler feeds the period
	assign t2_load = wr && (paddr == T2_COUNT_OFS);

	timer2_timebase #(
		.WIDTH(T2_WIDTH)
	) u_timer2 (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.run(tcfg_q[T2_ON_BIT]),
		.pre_sel(tcfg_q[T2_PRE_LSB +: 2]),
		.limit(period_q),
		.load(t2_load),
		.load_val(pwdata[7:0]),
		.count_q(t2_count),
		.low_bits(t2_low),
		.period_end(period_end)
	);

	assign timebase = {t2_count, t2_low};
	assign duty_buf = {duty_high_q, latch_q};
	assign duty_next = {duty_low_q, dlb_q};

	// period end delayed one cycle so the set lines up with the
	// clear: the pin then stands high for exactly duty time-base steps
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			period_end_q <= 1'b0;
		end else begin
			period_end_q <= period_end && pwm_mode;
		end
	end

	// output latch: set after period end, cleared at duty match;
	// a duty past the last time-base value never matches
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			out_q <= 1'b0;
		end else if (ctrl_zero_wr) begin
			out_q <= 1'b0;
		end else if (pwm_mode) begin
			if (period_end_q) begin
				out_q <= (duty_buf != '0);
			end else if (timebase == duty_buf) begin
				out_q <= 1'b0;
			end
		end
	end

	// the pin is driven only in pwm; both compare special modes
	// leave it to the port logic
	assign unit_output_pin_o = out_q;
	assign unit_output_pin_oe_n = !pwm_mode;

	// conversion start on the rising match in special event mode
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			match_prev_q <= 1'b0;
			adc_start_q <= 1'b0;
		end else begin
			match_prev_q <= match;
			adc_start_q <= special_mode && match && !match_prev_q &&
				adc_enable;
		end
	end
	assign adc_start = adc_start_q;

	// sticky flags, write one to clear; a set in the same cycle wins
	assign flag_set[MATCH_FLAG_BIT] = (mode_q[3:2] == MODE_CMP_GRP) &&
		match && !match_prev_q;
	assign flag_set[T2_FLAG_BIT] = period_end;
	assign flag_set[T1_OVF_FLAG_BIT] = t1_ovf;
	assign flag_clr = (wr && paddr == STATUS_OFS) ? pwdata[2:0] : 3'h0;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			flags_q <= 3'h0;
		end else begin
			flags_q <= (flags_q & ~flag_clr) | flag_set;
		end
	end

	// read mux; unused bits read zero
	always_comb begin
		rd_val = RDATA_ZERO;
		mapped = 1'b1;
		unique case (paddr)
			CTRL_OFS: rd_val[7:0] = {2'h0, dlb_q, mode_q};
			DUTY_LOW_OFS: rd_val[7:0] = duty_low_q;
			DUTY_HIGH_OFS: rd_val[7:0] = duty_high_q;
			PERIOD_OFS: rd_val[7:0] = period_q;
			T2_COUNT_OFS: rd_val[7:0] = t2_count;
			T1_COUNT_OFS: rd_val[15:0] = t1_count;
			TCFG_OFS: rd_val[4:0] = tcfg_q;
			STATUS_OFS: rd_val[2:0] = flags_q;
			default: mapped = 1'b0;
		endcase
	end

	// read data and error are caught in the setup cycle so they
	// come from flops; the value is one cycle older than the access
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			prdata_q <= RDATA_ZERO;
			pslverr_q <= 1'b0;
		end else if (setup_rd) begin
			prdata_q <= pwrite ? RDATA_ZERO : rd_val;
			pslverr_q <= !mapped;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	property p_sw_irq_pin;
		(mode_q == MODE_SW_IRQ) |-> unit_output_pin_oe_n;
	endproperty
	a_sw_irq_pin: assert property (p_sw_irq_pin)
		else $error("pin driven in software interrupt mode");

	property p_special_pin;
		special_mode |-> unit_output_pin_oe_n &&
			(!adc_start_q || $past(adc_enable));
	endproperty
	a_special_pin: assert property (p_special_pin)
		else $error("pin driven or stray start in special mode");

	property p_event_now;
		special_mode && (t1_count == {duty_high_q, duty_low_q})
			|-> special_event;
	endproperty
	a_event_now: assert property (p_event_now)
		else $error("special event late on match");

	property p_t1_clear;
		t1_clear && !t1_load |=> (t1_count == 16'h0000);
	endproperty
	a_t1_clear: assert property (p_t1_clear)
		else $error("timer1 not cleared after event");

	property p_no_ovf;
		t1_clear && !flags_q[T1_OVF_FLAG_BIT] |=>
			!flags_q[T1_OVF_FLAG_BIT];
	endproperty
	a_no_ovf: assert property (p_no_ovf)
		else $error("overflow flag set by special event");

	property p_no_clear;
		t1_tick && !t1_load && !match && (t1_count != 16'hffff)
			|=> (t1_count == $past(t1_count) + 16'h0001);
	endproperty
	a_no_clear: assert property (p_no_clear)
		else $error("timer1 reset without a match");

	property p_period_set;
		pwm_mode && period_end && (duty_next != '0)
			|=> (duty_high_q == $past(duty_low_q)) ##1
			(out_q || $past(ctrl_zero_wr) || !$past(pwm_mode));
	endproperty
	a_period_set: assert property (p_period_set)
		else $error("period end did not set pin and load duty");

	property p_high_ro;
		pwm_mode && wr && (paddr == DUTY_HIGH_OFS) && !period_end
			|=> $stable(duty_high_q);
	endproperty
	a_high_ro: assert property (p_high_ro)
		else $error("high duty register written in pwm");

	property p_duty_clear;
		pwm_mode && !period_end_q && !ctrl_zero_wr &&
			(timebase == duty_buf) |=> !out_q;
	endproperty
	a_duty_clear: assert property (p_duty_clear)
		else $error("pin not cleared at duty match");

	property p_zero_ctrl;
		ctrl_zero_wr |=> !out_q ##1 !out_q || pwm_mode;
	endproperty
	a_zero_ctrl: assert property (p_zero_ctrl)
		else $error("zero control write left latch high");

	property p_full_duty;
		pwm_mode && out_q && !period_end && !ctrl_zero_wr &&
			(duty_buf > {period_q, 2'h3}) |=> out_q;
	endproperty
	a_full_duty: assert property (p_full_duty)
		else $error("pin cleared although duty spans the period");

	c_special: cover property (special_mode && t1_clear);
	c_sw_irq: cover property (flag_set[MATCH_FLAG_BIT] &&
		mode_q == MODE_SW_IRQ);
	c_pwm_period: cover property (pwm_mode && period_end ##1 out_q);
	c_pwm_zero: cover property (pwm_mode && period_end &&
		duty_next == '0);
endmodule : ccp_compare_event_pwm

// [design/ccp_pkg.sv]
// constants shared by the compare/pwm unit and its two timers
// assumes an apb master with 8-bit byte addresses and 32-bit data
package ccp_pkg;
	// register byte offsets, one aligned word each
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] DUTY_LOW_OFS = 8'h04;
	localparam logic [7:0] DUTY_HIGH_OFS = 8'h08;
	localparam logic [7:0] PERIOD_OFS = 8'h0c;
	localparam logic [7:0] T2_COUNT_OFS = 8'h10;
	localparam logic [7:0] T1_COUNT_OFS = 8'h14;
	localparam logic [7:0] TCFG_OFS = 8'h18;
	localparam logic [7:0] STATUS_OFS = 8'h1c;
	// control register fields
	localparam int MODE_LSB = 0;
	localparam int DLB_LSB = 4;
	// timer configuration fields
	localparam int T1_ON_BIT = 0;
	localparam int T1_EXT_BIT = 1;
	localparam int T2_PRE_LSB = 2;
	localparam int T2_ON_BIT = 4;
	// status flag positions
	localparam int MATCH_FLAG_BIT = 0;
	localparam int T2_FLAG_BIT = 1;
	localparam int T1_OVF_FLAG_BIT = 2;
	// mode select codes
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_SW_IRQ = 4'ha;
	localparam logic [3:0] MODE_SPECIAL = 4'hb;
	localparam logic [1:0] MODE_CMP_GRP = 2'h2;
	localparam logic [1:0] MODE_PWM_GRP = 2'h3;
	// timer2 prescale selections
	localparam logic [1:0] PRE_1 = 2'h0;
	localparam logic [1:0] PRE_4 = 2'h1;
	// reset values
	localparam logic [7:0] PERIOD_RST = 8'hff;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
	// oscillator timing: one osc period per sys_clk
	localparam int OSC_PERIOD_NS = 10;
	localparam int OSC_PER_INSTR = 4;
	localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_INSTR - 1);
endpackage : ccp_pkg

// [design/timer1_counter.sv]
// 16-bit up counter stepped by a one-cycle tick
// assumes tick, clear and load come from logic on sys_clk
`timescale 1ns/100ps
module timer1_counter import ccp_pkg::*; #(
	parameter int WIDTH = 16
) (
	input wire logic sys_clk, // system clock
	input wire logic resetn, // async reset, active low
	input wire logic tick, // one step of the timer clock
	input wire logic clear, // reset the count at this tick
	input wire logic load, // software write of the count
	input wire logic [WIDTH-1:0] load_val, // value written
	output logic [WIDTH-1:0] count_q, // current count
	output logic overflow // pulse: count wrapped
);
	if (WIDTH < 2) begin : g_chk
		$error("timer1_counter: WIDTH too small");
	end

	// a special-event clear replaces the wrap, so no overflow is seen
	assign overflow = tick && !load && !clear && (&count_q);

	// load beats tick so a software write is never lost
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			count_q <= '0;
		end else if (load) begin
			count_q <= load_val;
		end else if (tick) begin
			count_q <= clear ? '0 : count_q + WIDTH'(1);
		end
	end
endmodule : timer1_counter

// [design/timer2_timebase.sv]
// 8-bit period timer with prescaler, giving a 10-bit time base
// assumes limit and prescale come from registers on sys_clk
`timescale 1ns/100ps
module timer2_timebase import ccp_pkg::*; #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk, // system clock, one osc period
	input wire logic resetn, // async reset, active low
	input wire logic run, // timer2 enabled
	input wire logic [1:0] pre_sel, // prescale 1, 4 or 16
	input wire logic [WIDTH-1:0] limit, // period limit
	input wire logic load, // software write of the count
	input wire logic [WIDTH-1:0] load_val, // value written
	output logic [WIDTH-1:0] count_q, // timer2 count
	output logic [1:0] low_bits, // two lower time-base bits
	output logic period_end // pulse: count cleared at limit
);
	logic [5:0] sub_q;
	logic [5:0] sub_max;
	logic step;

	if (WIDTH < 2) begin : g_chk
		$error("timer2_timebase: WIDTH too small");
	end

	// osc phases at 1:1, else the top prescaler bits
	always_comb begin
		unique case (pre_sel)
			PRE_1: begin
				sub_max = 6'h03;
				low_bits = sub_q[1:0];
			end
			PRE_4: begin
				sub_max = 6'h0f;
				low_bits = sub_q[3:2];
			end
			default: begin
				sub_max = 6'h3f;
				low_bits = sub_q[5:4];
			end
		endcase
	end

	assign step = run && !load && (sub_q == sub_max);
	assign period_end = step && (count_q == limit);

	// a stopped timer holds both count and prescaler
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sub_q <= '0;
			count_q <= '0;
		end else if (load) begin
			sub_q <= '0;
			count_q <= load_val;
		end else if (run) begin
			sub_q <= step ? '0 : sub_q + 6'h01;
			if (period_end) begin
				count_q <= '0;
			end else if (step) begin
				count_q <= count_q + WIDTH'(1);
			end
		end
	end
endmodule : timer2_timebase

// [tb/pwm_load.sv]
// behavioural load on the unit output pin, measures each pulse
// assumes the board pulls the pin low whenever the unit lets go
`timescale 1ns/100ps
module pwm_load (
	input wire logic sys_clk, // system clock
	input wire logic resetn, // async reset, active low
	input wire logic pin_o, // level driven by the unit
	input wire logic pin_oe_n, // low while the unit drives
	output logic pin_wire, // level seen on the board
	output logic [15:0] high_q, // length of the last high time
	output logic [15:0] period_q, // distance between two rises
	output logic [15:0] rises_q // rising edges seen so far
);
	logic prev_q;
	logic [15:0] run_q;
	logic [15:0] hi_q;

	// pull-down: an undriven pin must not keep its last level
	assign pin_wire = pin_oe_n ? 1'b0 : pin_o;

	// cycle counts are taken at sys_clk resolution, enough for pwm
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			prev_q <= 1'b0;
			run_q <= 16'h0000;
			hi_q <= 16'h0000;
			high_q <= 16'h0000;
			period_q <= 16'h0000;
			rises_q <= 16'h0000;
		end else begin
			prev_q <= pin_wire;
			run_q <= run_q + 16'h0001;
			if (pin_wire && !prev_q) begin
				period_q <= run_q;
				run_q <= 16'h0001;
				hi_q <= 16'h0001;
				rises_q <= rises_q + 16'h0001;
			end else if (pin_wire) begin
				hi_q <= hi_q + 16'h0001;
			end
			if (!pin_wire && prev_q) begin
				high_q <= hi_q;
			end
		end
	end
endmodule : pwm_load

// [tb/tb.sv]
// self-checking bench for the compare/pwm unit
// assumes the unit answers apb with no wait states and a pin load
`timescale 1ns/100ps
module tb import ccp_pkg::*; ();
	logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic t1_ext_in, adc_enable, adc_start, special_event;
	logic pin_o, pin_oe_n, pin_wire;
	logic [15:0] load_high, load_period, load_rises;
	int num_errors, checked, cycles;

	ccp_compare_event_pwm uut (.sys_clk(sys_clk), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .t1_ext_in(t1_ext_in),
		.adc_enable(adc_enable), .adc_start(adc_start),
		.special_event(special_event), .unit_output_pin_o(pin_o),
		.unit_output_pin_oe_n(pin_oe_n));

	pwm_load load (.sys_clk(sys_clk), .resetn(resetn), .pin_o(pin_o),
		.pin_oe_n(pin_oe_n), .pin_wire(pin_wire), .high_q(load_high),
		.period_q(load_period), .rises_q(load_rises));

	// free-running 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	// a hang counts as a mismatch and still reaches the report
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// one apb transfer; the request holds until pready is seen
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		penable <= 1'b0;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, RDATA_ZERO, r, e);
	endtask : rd

	// duty goes into the low register plus two control bits
	task automatic set_duty(input logic [9:0] d);
		wr(DUTY_LOW_OFS, {24'h00_0000, d[9:2]});
		wr(CTRL_OFS, {26'h000_0000, d[1:0], 4'hc});
	endtask : set_duty

	task automatic t_reset();
		logic [31:0] r;
		logic e;
		chk(32'(pin_o), 32'h0, "pin latch after reset");
		chk(32'(pin_oe_n), 32'h1, "pin undriven after reset");
		rd(PERIOD_OFS, r);
		chk(r, 32'h0000_00ff, "period limit reset");
		rd(CTRL_OFS, r);
		chk(r, RDATA_ZERO, "control reset");
		apb(1'b0, 8'h20, RDATA_ZERO, r, e);
		chk(32'(e), 32'h1, "unmapped read error");
		$display("test reset done");
	endtask : t_reset

	task automatic t_pwm();
		wr(PERIOD_OFS, 32'h0000_0003);
		wr(TCFG_OFS, 32'h0000_0010);
		set_duty(10'h006);
		repeat (60) @(posedge sys_clk);
		chk(32'(load_period), 32'h10, "period at prescale 1");
		chk(32'(load_high), 32'h6, "high time prescale 1");
		wr(TCFG_OFS, 32'h0000_0014);
		repeat (200) @(posedge sys_clk);
		chk(32'(load_period), 32'h40, "period at prescale 4");
		chk(32'(load_high), 32'h18, "high time prescale 4");
		wr(TCFG_OFS, 32'h0000_0010);
		repeat (40) @(posedge sys_clk);
		$display("test pwm timing done");
	endtask : t_pwm

	// new duty written just after a rise must wait for period end
	task automatic t_buffer();
		logic [15:0] r0;
		logic [31:0] r;
		int n;
		r0 = load_rises;
		n = 0;
		while (load_rises === r0 && n < 40) begin
			@(posedge sys_clk);
			n++;
		end
		set_duty(10'h00a);
		n = 0;
		while (pin_wire !== 1'b0 && n < 40) begin
			@(posedge sys_clk);
			n++;
		end
		@(posedge sys_clk);
		chk(32'(load_high), 32'h6, "old duty kept");
		repeat (40) @(posedge sys_clk);
		chk(32'(load_high), 32'ha, "new duty taken");
		wr(DUTY_HIGH_OFS, 32'h0000_0055);
		rd(DUTY_HIGH_OFS, r);
		chk(r, 32'h0000_0002, "high duty read-only");
		$display("test duty buffer done");
	endtask : t_buffer

	task automatic t_extremes();
		logic [15:0] r0;
		int lows;
		set_duty(10'h000);
		repeat (40) @(posedge sys_clk);
		r0 = load_rises;
		repeat (40) @(posedge sys_clk);
		chk(32'(load_rises), 32'(r0), "zero duty never sets");
		set_duty(10'h010);
		repeat (40) @(posedge sys_clk);
		lows = 0;
		repeat (40) begin
			@(posedge sys_clk);
			if (pin_wire !== 1'b1) lows++;
		end
		chk(32'(lows), 32'h0, "full duty stays high");
		wr(CTRL_OFS, RDATA_ZERO);
		chk(32'(pin_o), 32'h0, "control clear drops latch");
		wr(TCFG_OFS, RDATA_ZERO);
		$display("test duty extremes done");
	endtask : t_extremes

	// timer1 runs from the internal tick, never the async pin
	task automatic cmp_setup(input logic [3:0] mode);
		wr(TCFG_OFS, RDATA_ZERO);
		wr(STATUS_OFS, 32'h0000_0007);
		wr(T1_COUNT_OFS, RDATA_ZERO);
		wr(DUTY_HIGH_OFS, RDATA_ZERO);
		wr(DUTY_LOW_OFS, 32'h0000_0005);
		wr(CTRL_OFS, {28'h000_0000, mode});
		wr(TCFG_OFS, 32'h0000_0001);
	endtask : cmp_setup

	task automatic t_flag();
		logic [31:0] r;
		int bad;
		cmp_setup(MODE_SW_IRQ);
		bad = 0;
		repeat (40) begin
			@(posedge sys_clk);
			if (special_event || adc_start || !pin_oe_n) bad++;
		end
		chk(32'(bad), 32'h0, "flag mode quiet outputs");
		rd(STATUS_OFS, r);
		chk(r, 32'h0000_0001, "flag mode match flag");
		$display("test flag mode done");
	endtask : t_flag

	task automatic t_special();
		logic [31:0] r;
		int n, hi, adc;
		adc_enable <= 1'b1;
		cmp_setup(MODE_SPECIAL);
		n = 0;
		while (special_event !== 1'b1 && n < 60) begin
			@(posedge sys_clk);
			n++;
		end
		hi = 1;
		adc = 0;
		repeat (8) begin
			@(posedge sys_clk);
			if (special_event === 1'b1) hi++;
			if (adc_start === 1'b1) adc++;
		end
		chk(32'(hi), 32'h4, "event until next tick");
		chk(32'(adc), 32'h1, "one conversion start");
		chk(32'(pin_oe_n), 32'h1, "pin undriven");
		rd(T1_COUNT_OFS, r);
		chk(32'(r < 32'h5), 32'h1, "timer1 was reset");
		rd(STATUS_OFS, r);
		chk(r, 32'h0000_0001, "no overflow flag");
		wr(TCFG_OFS, RDATA_ZERO);
		wr(T1_COUNT_OFS, 32'h0000_0005);
		chk(32'(special_event), 32'h1, "event at once");
		wr(DUTY_LOW_OFS, 32'h0000_0009);
		chk(32'(special_event), 32'h0, "match removed");
		wr(TCFG_OFS, 32'h0000_0001);
		repeat (4) @(posedge sys_clk);
		rd(T1_COUNT_OFS, r);
		chk(32'((r > 32'h5) && (r < 32'h9)), 32'h1, "no reset");
		$display("test special event done");
	endtask : t_special

	// every input gets a value at time zero, reset held ten cycles
	initial begin
		num_errors = 0;
		checked = 0;
		cycles = 0;
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = RDATA_ZERO;
		t1_ext_in = 1'b0;
		adc_enable = 1'b0;
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		t_reset();
		t_pwm();
		t_buffer();
		t_extremes();
		t_flag();
		t_special();
		conclude();
	end
endmodule : tb
